/* File: hdl/sbct_pkg.sv */
// Shared constants, types and helpers of the split bulk/control translator link.
`default_nettype none
package sbct_pkg;
   localparam int NBUF = 2;
   localparam int IDX_W = 1;
   localparam int ADDR_W = 7;
   localparam int EP_W = 4;
   localparam int DATA_W = 8;
   localparam int CLK_PERIOD_NS = 4;
   localparam int HS_TIMEOUT_NS = 64;
   localparam int TMO_W = 5;
   localparam logic [TMO_W-1:0] HS_TIMEOUT_CYC = TMO_W'(HS_TIMEOUT_NS / CLK_PERIOD_NS);
   localparam logic [1:0] ERR_LIMIT = 2'h3;
   localparam logic [1:0] ERR_RESET = 2'h0;

   typedef enum logic [1:0] {
      HS_ACK = 2'h0,
      HS_NAK = 2'h1,
      HS_NYET = 2'h2,
      HS_STALL = 2'h3
   } sbct_hs_t;

   typedef enum logic [1:0] {
      DS_ACK = 2'h0,
      DS_NAK = 2'h1,
      DS_STALL = 2'h2,
      DS_ERR = 2'h3
   } sbct_ds_t;

   typedef enum logic [1:0] {
      BUF_OLD = 2'h0,
      BUF_PEND = 2'h1,
      BUF_READY = 2'h2
   } sbct_bst_t;

   typedef enum logic {
      TOK_SS = 1'h0,
      TOK_CS = 1'h1
   } sbct_tok_t;

   // Control endpoints are bidirectional, so direction only separates bulk endpoints.
   function automatic logic sbct_ep_match(input logic [ADDR_W-1:0] a1, input logic [EP_W-1:0] e1,
                                          input logic d1, input logic ctrl,
                                          input logic [ADDR_W-1:0] a2, input logic [EP_W-1:0] e2,
                                          input logic d2);
      sbct_ep_match = (a1 == a2) && (e1 == e2) && (ctrl || (d1 == d2));
   endfunction

   function automatic sbct_hs_t sbct_ds_to_hs(input sbct_ds_t r);
      case (r)
         DS_ACK: sbct_ds_to_hs = HS_ACK;
         DS_NAK: sbct_ds_to_hs = HS_NAK;
         default: sbct_ds_to_hs = HS_STALL;
      endcase
   endfunction
endpackage
`default_nettype wire

/* File: hdl/sbct_if.sv */
// Split-transaction link between the host controller end and the translator end.
`default_nettype none
interface sbct_if;
   import sbct_pkg::*;
   logic tok_valid;
   sbct_tok_t tok_kind;
   logic tok_bad;
   logic [ADDR_W-1:0] tok_addr;
   logic [EP_W-1:0] tok_ep;
   logic tok_dir;
   logic tok_ctrl;
   logic [DATA_W-1:0] tok_wdata;
   logic hs_valid;
   sbct_hs_t hs_code;
   logic [DATA_W-1:0] hs_rdata;

   modport host_end (
      output tok_valid, tok_kind, tok_bad, tok_addr, tok_ep, tok_dir, tok_ctrl, tok_wdata,
      input hs_valid, hs_code, hs_rdata
   );
   modport dev_end (
      input tok_valid, tok_kind, tok_bad, tok_addr, tok_ep, tok_dir, tok_ctrl, tok_wdata,
      output hs_valid, hs_code, hs_rdata
   );
endinterface
`default_nettype wire

/* File: hdl/sbct_dev.sv */
// Translator end: high-speed handler, bulk/control buffers and full/low-speed handler.
//
// Overview of operation
// R1 - Free buffer takes start-split, answer ACK.
// R2 - Host waits for complete-split before next start-split.
// R3 - Busy matching buffer: answer ACK, drop data.
// R4 - Host retries errors below three, else halts.
// R5 - Host system delay leaves error count alone.
// R6 - Host clears error count on normal completion.
// R7 - Result becomes nak, stall or ack as received.
// R8 - Local retry; three errors recorded as stall.
// R9 - No local retry after ACK, NAK, STALL.
// R10 - Complete-split on pending buffer gets NYET.
// R11 - Complete-split without buffer gets STALL.
// R12 - Finished transaction stored, pending becomes ready.
// R13 - Answered ready buffer becomes old, keeps result.
// R14 - Host retries failed complete-split first, counts error.
// R15 - On STALL host halts all requests until cleared.
// R16 - On ACK host records result, moves on.
// R17 - On NAK host reports result, goes idle, no count.
// R18 - Host retries start-split until count reaches three.
// R19 - After final answer host may start anew.
// R20 - Match address, endpoint; direction only for bulk.
// R21 - No free buffer: answer NAK, not error.
// R22 - At least two transaction buffers exist.
// R23 - Missing packet or bad CRC: no handshake.
// R24 - Reset leaves every buffer old and free.
`default_nettype none
module sbct_dev
   import sbct_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   sbct_if.dev_end lk,
   output logic ds_start,
   output logic [ADDR_W-1:0] ds_addr,
   output logic [EP_W-1:0] ds_ep,
   output logic ds_dir,
   output logic [DATA_W-1:0] ds_wdata,
   input wire logic ds_done,
   input wire sbct_ds_t ds_result,
   input wire logic [DATA_W-1:0] ds_rdata
);
   typedef enum logic {
      D_IDLE = 1'h0,
      D_WAIT = 1'h1
   } sbct_dst_t;

   // Buffer contents; the array size sets how many endpoints may be in flight.
   sbct_bst_t buf_state_reg [NBUF]; // [R22]
   logic [ADDR_W-1:0] buf_addr_reg [NBUF];
   logic [EP_W-1:0] buf_ep_reg [NBUF];
   logic buf_dir_reg [NBUF];
   logic [DATA_W-1:0] buf_wdata_reg [NBUF];
   sbct_hs_t buf_res_reg [NBUF];
   logic [DATA_W-1:0] buf_rdata_reg [NBUF];

   logic hs_valid_reg;
   sbct_hs_t hs_code_reg;
   logic [DATA_W-1:0] hs_rdata_reg;

   sbct_dst_t dstate_reg;
   logic [IDX_W-1:0] ds_idx_reg;
   logic [1:0] ds_err_reg;
   logic ds_start_reg;
   logic [ADDR_W-1:0] ds_addr_reg;
   logic [EP_W-1:0] ds_ep_reg;
   logic ds_dir_reg;
   logic [DATA_W-1:0] ds_wdata_reg;

   logic [NBUF-1:0] hit;
   logic [NBUF-1:0] is_old;
   logic [NBUF-1:0] is_pend;
   logic hit_found;
   logic free_found;
   logic pend_found;
   logic [IDX_W-1:0] hit_idx;
   logic [IDX_W-1:0] free_idx;
   logic [IDX_W-1:0] pend_idx;

   for (genvar i = 0; i < NBUF; i++) begin : g_cmp
      assign hit[i] = sbct_ep_match(lk.tok_addr, lk.tok_ep, lk.tok_dir, lk.tok_ctrl,
                                    buf_addr_reg[i], buf_ep_reg[i], buf_dir_reg[i]); // [R20]
      assign is_old[i] = (buf_state_reg[i] == BUF_OLD);
      assign is_pend[i] = (buf_state_reg[i] == BUF_PEND);
   end

   // Lowest index wins in every search, so the choice is repeatable.
   always_comb begin
      hit_found = 1'b0;
      free_found = 1'b0;
      pend_found = 1'b0;
      hit_idx = '0;
      free_idx = '0;
      pend_idx = '0;
      for (int i = 0; i < NBUF; i++) begin
         if (hit[i] && !hit_found) begin
            hit_found = 1'b1;
            hit_idx = IDX_W'(i);
         end
         if (is_old[i] && !free_found) begin
            free_found = 1'b1;
            free_idx = IDX_W'(i);
         end
         if (is_pend[i] && !pend_found) begin
            pend_found = 1'b1;
            pend_idx = IDX_W'(i);
         end
      end
   end

   // A corrupted or incomplete request is dropped whole, so the host times out.
   wire tok_ok = lk.tok_valid && !lk.tok_bad; // [R23]
   wire is_ss = tok_ok && (lk.tok_kind == TOK_SS);
   wire is_cs = tok_ok && (lk.tok_kind == TOK_CS);
   wire hit_busy = hit_found && (buf_state_reg[hit_idx] != BUF_OLD);
   wire hit_pend = hit_found && (buf_state_reg[hit_idx] == BUF_PEND);
   wire hit_ready = hit_found && (buf_state_reg[hit_idx] == BUF_READY);
   wire ss_retry = is_ss && hit_busy; // [R3]
   wire ss_new = is_ss && !hit_busy && (hit_found || free_found); // [R1]
   wire ss_full = is_ss && !hit_busy && !hit_found && !free_found; // [R21]
   wire [IDX_W-1:0] new_idx = hit_found ? hit_idx : free_idx;
   wire cs_nyet = is_cs && hit_pend; // [R10]
   wire cs_ready = is_cs && hit_ready;
   wire cs_none = is_cs && !hit_pend && !hit_ready; // [R11]

   wire ds_fin = (dstate_reg == D_WAIT) && ds_done;
   wire ds_is_err = (ds_result == DS_ERR);
   wire [1:0] ds_err_next = ds_err_reg + 2'h1;
   // Bus errors are absorbed here; three of them turn into a stall result.
   wire ds_give_up = ds_fin && ds_is_err && (ds_err_next >= ERR_LIMIT); // [R8]
   wire ds_retry = ds_fin && ds_is_err && (ds_err_next < ERR_LIMIT); // [R8]
   wire ds_final = ds_fin && (!ds_is_err || ds_give_up); // [R9]
   wire sbct_hs_t ds_hs = ds_give_up ? HS_STALL : sbct_ds_to_hs(ds_result); // [R7]
   wire ds_launch = (dstate_reg == D_IDLE) && pend_found;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         hs_valid_reg <= 1'b0;
         hs_code_reg <= HS_ACK;
         hs_rdata_reg <= '0;
      end else begin
         hs_valid_reg <= ss_retry || ss_new || ss_full || cs_nyet || cs_ready || cs_none;
         hs_rdata_reg <= cs_ready ? buf_rdata_reg[hit_idx] : '0;
         if (ss_full)
            hs_code_reg <= HS_NAK; // [R21]
         else if (cs_nyet)
            hs_code_reg <= HS_NYET; // [R10]
         else if (cs_none)
            hs_code_reg <= HS_STALL; // [R11]
         else if (cs_ready)
            hs_code_reg <= buf_res_reg[hit_idx];
         else
            hs_code_reg <= HS_ACK; // [R1] [R3]
      end
   end

   // Each buffer state is touched by one event per cycle: start-splits only claim
   // old buffers, the bus side only finishes pending ones, complete-splits only retire ready ones.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         for (int i = 0; i < NBUF; i++) begin
            buf_state_reg[i] <= BUF_OLD; // [R24]
            buf_addr_reg[i] <= '0;
            buf_ep_reg[i] <= '0;
            buf_dir_reg[i] <= 1'b0;
            buf_wdata_reg[i] <= '0;
            buf_res_reg[i] <= HS_ACK;
            buf_rdata_reg[i] <= '0;
         end
      end else begin
         if (ss_new) begin
            buf_state_reg[new_idx] <= BUF_PEND; // [R1]
            buf_addr_reg[new_idx] <= lk.tok_addr;
            buf_ep_reg[new_idx] <= lk.tok_ep;
            buf_dir_reg[new_idx] <= lk.tok_dir;
            buf_wdata_reg[new_idx] <= lk.tok_wdata;
         end
         if (cs_ready)
            buf_state_reg[hit_idx] <= BUF_OLD; // [R13]
         if (ds_final) begin
            buf_state_reg[ds_idx_reg] <= BUF_READY; // [R12]
            buf_res_reg[ds_idx_reg] <= ds_hs; // [R7]
            buf_rdata_reg[ds_idx_reg] <= ds_rdata;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         dstate_reg <= D_IDLE;
         ds_idx_reg <= '0;
         ds_err_reg <= ERR_RESET;
         ds_start_reg <= 1'b0;
         ds_addr_reg <= '0;
         ds_ep_reg <= '0;
         ds_dir_reg <= 1'b0;
         ds_wdata_reg <= '0;
      end else begin
         ds_start_reg <= ds_launch || ds_retry; // [R8]
         case (dstate_reg)
            D_IDLE: begin
               if (ds_launch) begin
                  dstate_reg <= D_WAIT;
                  ds_idx_reg <= pend_idx;
                  ds_err_reg <= ERR_RESET;
                  ds_addr_reg <= buf_addr_reg[pend_idx];
                  ds_ep_reg <= buf_ep_reg[pend_idx];
                  ds_dir_reg <= buf_dir_reg[pend_idx];
                  ds_wdata_reg <= buf_wdata_reg[pend_idx];
               end
            end
            D_WAIT: begin
               if (ds_retry)
                  ds_err_reg <= ds_err_next; // [R8]
               if (ds_final)
                  dstate_reg <= D_IDLE; // [R9]
            end
            default: dstate_reg <= D_IDLE;
         endcase
      end
   end

   assign lk.hs_valid = hs_valid_reg;
   assign lk.hs_code = hs_code_reg;
   assign lk.hs_rdata = hs_rdata_reg;
   assign ds_start = ds_start_reg;
   assign ds_addr = ds_addr_reg;
   assign ds_ep = ds_ep_reg;
   assign ds_dir = ds_dir_reg;
   assign ds_wdata = ds_wdata_reg;
endmodule // sbct_dev
`default_nettype wire

/* File: hdl/sbct_host.sv */
// Host controller end: issues start- and complete-splits for one transfer at a time.
`default_nettype none
module sbct_host
   import sbct_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   sbct_if.host_end lk,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [EP_W-1:0] req_ep,
   input wire logic req_dir,
   input wire logic req_ctrl,
   input wire logic [DATA_W-1:0] req_wdata,
   input wire logic link_corrupt,
   input wire logic sys_hold,
   input wire logic halt_clear,
   output logic done,
   output sbct_hs_t done_code,
   output logic [DATA_W-1:0] done_rdata,
   output logic halted,
   output logic [1:0] err_count
);
   typedef enum logic [2:0] {
      H_IDLE = 3'h0,
      H_SS = 3'h1,
      H_SSW = 3'h2,
      H_CS = 3'h3,
      H_CSW = 3'h4
   } sbct_hst_t;

   sbct_hst_t state_reg;
   logic [TMO_W-1:0] tmo_reg;
   logic [1:0] err_reg;
   logic halted_reg;
   logic done_reg;
   sbct_hs_t done_code_reg;
   logic [DATA_W-1:0] done_rdata_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [EP_W-1:0] ep_reg;
   logic dir_reg;
   logic ctrl_reg;
   logic [DATA_W-1:0] wdata_reg;

   wire waiting = (state_reg == H_SSW) || (state_reg == H_CSW);
   wire got = waiting && lk.hs_valid;
   wire timed_out = waiting && !lk.hs_valid && (tmo_reg >= HS_TIMEOUT_CYC);
   // A system hold-off aborts the attempt without charging the endpoint.
   wire held = timed_out && sys_hold; // [R5]
   wire bus_err = timed_out && !sys_hold;
   wire [1:0] err_inc = err_reg + 2'h1;
   wire give_up = bus_err && (err_inc >= ERR_LIMIT); // [R4]

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_reg <= H_IDLE;
         tmo_reg <= '0;
         err_reg <= ERR_RESET;
         halted_reg <= 1'b0;
         done_reg <= 1'b0;
         done_code_reg <= HS_ACK;
         done_rdata_reg <= '0;
         addr_reg <= '0;
         ep_reg <= '0;
         dir_reg <= 1'b0;
         ctrl_reg <= 1'b0;
         wdata_reg <= '0;
      end else begin
         done_reg <= 1'b0;
         tmo_reg <= waiting ? tmo_reg + TMO_W'(1) : '0;
         if (halt_clear && state_reg == H_IDLE)
            halted_reg <= 1'b0; // [R15]
         if (bus_err)
            err_reg <= err_inc; // [R4] [R14]
         if (give_up) begin
            halted_reg <= 1'b1; // [R4]
            done_reg <= 1'b1;
            done_code_reg <= HS_STALL;
            state_reg <= H_IDLE;
         end
         case (state_reg)
            H_IDLE: begin
               if (req_valid && !halted_reg) begin
                  state_reg <= H_SS;
                  err_reg <= ERR_RESET;
                  addr_reg <= req_addr;
                  ep_reg <= req_ep;
                  dir_reg <= req_dir;
                  ctrl_reg <= req_ctrl;
                  wdata_reg <= req_wdata;
               end
            end
            H_SS: state_reg <= H_SSW;
            H_CS: state_reg <= H_CSW;
            H_SSW: begin
               if (got && lk.hs_code == HS_ACK) begin
                  err_reg <= ERR_RESET; // [R6]
                  state_reg <= H_CS; // [R2]
               end else if (got && lk.hs_code == HS_NAK) begin
                  done_reg <= 1'b1; // [R21]
                  done_code_reg <= HS_NAK;
                  state_reg <= H_IDLE;
               end else if (got || held || (bus_err && !give_up))
                  state_reg <= H_SS; // [R18]
            end
            H_CSW: begin
               if (got && lk.hs_code == HS_NYET)
                  state_reg <= H_CS; // [R10]
               else if (got) begin
                  err_reg <= ERR_RESET; // [R6]
                  done_reg <= 1'b1; // [R16] [R17] [R19]
                  done_code_reg <= lk.hs_code;
                  done_rdata_reg <= lk.hs_rdata;
                  halted_reg <= (lk.hs_code == HS_STALL); // [R15]
                  state_reg <= H_IDLE;
               end else if (held || (bus_err && !give_up))
                  state_reg <= H_CS; // [R14]
            end
            default: state_reg <= H_IDLE;
         endcase
      end
   end

   wire sending = (state_reg == H_SS) || (state_reg == H_CS);
   assign lk.tok_valid = sending;
   assign lk.tok_kind = (state_reg == H_CS) ? TOK_CS : TOK_SS;
   assign lk.tok_bad = sending && link_corrupt;
   assign lk.tok_addr = addr_reg;
   assign lk.tok_ep = ep_reg;
   assign lk.tok_dir = dir_reg;
   assign lk.tok_ctrl = ctrl_reg;
   assign lk.tok_wdata = wdata_reg;
   assign req_ready = (state_reg == H_IDLE) && !halted_reg;
   assign done = done_reg;
   assign done_code = done_code_reg;
   assign done_rdata = done_rdata_reg;
   assign halted = halted_reg;
   assign err_count = err_reg;
endmodule // sbct_host
`default_nettype wire

/* File: tb/sbct_link_properties.sv */
// Protocol checker watching the link between the host end and the translator end.
`default_nettype none
module sbct_link_properties
   import sbct_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic tok_valid,
   input wire sbct_tok_t tok_kind,
   input wire logic tok_bad,
   input wire logic hs_valid,
   input wire sbct_hs_t hs_code,
   input wire logic [DATA_W-1:0] hs_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   wire logic tok_good;
   logic ss_reg;
   logic acked_reg;
   logic [1:0] cs_err_reg;
   assign tok_good = tok_valid && !tok_bad;

   // Three failed complete-splits end the wait, so the host may start afresh.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ss_reg <= 1'b0;
         acked_reg <= 1'b0;
         cs_err_reg <= 2'h0;
      end else begin
         ss_reg <= tok_good && tok_kind == TOK_SS;
         if (hs_valid && ss_reg && hs_code == HS_ACK) begin
            acked_reg <= 1'b1;
            cs_err_reg <= 2'h0;
         end else if ((hs_valid && !ss_reg && hs_code != HS_NYET) || cs_err_reg == ERR_LIMIT) begin
            acked_reg <= 1'b0;
         end
         if (tok_valid && tok_bad && tok_kind == TOK_CS) begin
            cs_err_reg <= cs_err_reg + 2'h1;
         end
      end
   end

   ans_next_a: assert property (tok_good |=> hs_valid)
      else $error("valid token got no handshake");
   bad_silent_a: assert property (tok_valid && tok_bad |=> !hs_valid)
      else $error("damaged token was answered");
   hs_cause_a: assert property (hs_valid |-> $past(tok_good))
      else $error("handshake without a token");
   ss_no_nyet_a: assert property (tok_good && tok_kind == TOK_SS |=> hs_code != HS_NYET)
      else $error("start-split answered with not-yet");
   nyet_empty_a: assert property (hs_valid && hs_code == HS_NYET |-> hs_rdata == 8'h00)
      else $error("not-yet answer carries data");
   ss_no_data_a: assert property (tok_good && tok_kind == TOK_SS |=> hs_rdata == 8'h00)
      else $error("start-split answer carries data");
   cs_first_a: assert property (tok_valid && acked_reg |-> tok_kind == TOK_CS)
      else $error("start-split sent while complete-split owed");
   tok_gap_a: assert property (tok_valid |=> !tok_valid)
      else $error("tokens sent back to back");

   cover property (tok_good && tok_kind == TOK_SS ##1 hs_valid && hs_code == HS_ACK);
   cover property (hs_valid && hs_code == HS_NYET);
   cover property (hs_valid && hs_code == HS_STALL);
   cover property (tok_valid && tok_bad && tok_kind == TOK_CS);
endmodule // sbct_link_properties
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the split bulk/control link with both ends joined.
`default_nettype none
module tb
   import sbct_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic req_valid = 1'b0;
   logic req_dir = 1'b0;
   logic req_ctrl = 1'b0;
   logic [ADDR_W-1:0] req_addr = 7'h00;
   logic [EP_W-1:0] req_ep = 4'h0;
   logic [DATA_W-1:0] req_wdata = 8'h00;
   logic link_corrupt = 1'b0;
   logic sys_hold = 1'b0;
   logic halt_clear = 1'b0;
   logic ds_done = 1'b0;
   sbct_ds_t ds_result = DS_ACK;
   logic [DATA_W-1:0] ds_rdata = 8'h00;
   logic req_ready, done, halted, ds_start, ds_dir;
   sbct_hs_t done_code;
   logic [DATA_W-1:0] done_rdata, ds_wdata;
   logic [1:0] err_count;
   logic [ADDR_W-1:0] ds_addr;
   logic [EP_W-1:0] ds_ep;
   int n_errors = 0;
   int total_checks = 0;
   int n_launch = 0;
   int n_nyet = 0;

   sbct_if lk_if();
   sbct_host sbct_host_inst (.clk_sys, .sys_rst, .lk(lk_if.host_end), .req_valid, .req_ready,
      .req_addr, .req_ep, .req_dir, .req_ctrl, .req_wdata, .link_corrupt, .sys_hold,
      .halt_clear, .done, .done_code, .done_rdata, .halted, .err_count);
   sbct_dev sbct_dev_inst (.clk_sys, .sys_rst, .lk(lk_if.dev_end), .ds_start, .ds_addr,
      .ds_ep, .ds_dir, .ds_wdata, .ds_done, .ds_result, .ds_rdata);
   sbct_link_properties sbct_link_properties_inst (.clk_sys, .sys_rst,
      .tok_valid(lk_if.tok_valid), .tok_kind(lk_if.tok_kind), .tok_bad(lk_if.tok_bad),
      .hs_valid(lk_if.hs_valid), .hs_code(lk_if.hs_code), .hs_rdata(lk_if.hs_rdata));

   initial begin
      forever #2 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      if (ds_start === 1'b1) n_launch++;
      if (lk_if.hs_valid === 1'b1 && lk_if.hs_code === HS_NYET) n_nyet++;
   end

   task automatic wrap_up();
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic req(input logic [ADDR_W-1:0] a, input logic [EP_W-1:0] e, input logic d,
                      input logic c, input logic [DATA_W-1:0] w);
      int n = 0;
      while (req_ready !== 1'b1 && n < 100) begin
         tick(1);
         n++;
      end
      chk(16'(req_ready), 16'h1);
      {req_addr, req_ep, req_dir, req_ctrl, req_wdata} = {a, e, d, c, w};
      req_valid = 1'b1;
      tick(1);
      req_valid = 1'b0;
   endtask

   task automatic wait_done(input sbct_hs_t code, input logic [DATA_W-1:0] rd, input logic use_rd);
      int n = 0;
      while (done !== 1'b1 && n < 400) begin
         tick(1);
         n++;
      end
      chk(16'(done), 16'h1);
      chk(16'(done_code), 16'(code));
      if (use_rd) chk(16'(done_rdata), 16'(rd));
   endtask

   task automatic ds_pulse(input sbct_ds_t r, input logic [DATA_W-1:0] rd);
      ds_result = r;
      ds_rdata = rd;
      ds_done = 1'b1;
      tick(1);
      ds_done = 1'b0;
      ds_rdata = ~rd;
   endtask

   task automatic ds_serve(input int n_err, input sbct_ds_t r, input logic [DATA_W-1:0] rd);
      int n;
      for (int i = 0; i <= n_err && i < 3; i++) begin
         n = 0;
         while (ds_start !== 1'b1 && n < 300) begin
            tick(1);
            n++;
         end
         chk(16'(ds_start), 16'h1);
         tick(3);
         ds_pulse((i < n_err) ? DS_ERR : r, rd);
      end
   endtask

   task automatic clr_halt();
      halt_clear = 1'b1;
      tick(1);
      halt_clear = 1'b0;
   endtask

   task automatic t_results();
      sbct_ds_t res [3] = '{DS_ACK, DS_NAK, DS_STALL};
      sbct_hs_t exp [3] = '{HS_ACK, HS_NAK, HS_STALL};
      int l0;
      int y0;
      for (int k = 0; k < 3; k++) begin
         l0 = n_launch;
         y0 = n_nyet;
         req(7'h05, 4'h1, 1'b0, 1'b0, 8'h40 + 8'(k));
         ds_serve(0, res[k], 8'h10 + 8'(k));
         chk({ds_addr, ds_ep, ds_dir, ds_wdata[3:0]}, {7'h05, 4'h1, 1'b0, 4'(k)});
         wait_done(exp[k], 8'h10 + 8'(k), k == 0);
         chk(16'(n_launch - l0), 16'h1);
         chk(16'(n_nyet > y0), 16'h1);
         if (k < 2) chk(16'(err_count), 16'h0);
         if (k == 2) chk(16'(halted), 16'h1);
         clr_halt();
      end
   endtask

   task automatic t_local();
      int l0;
      for (int n = 2; n < 4; n++) begin
         l0 = n_launch;
         req(7'h06, 4'h2, 1'b1, 1'b0, 8'h00);
         ds_serve(n, DS_ACK, 8'h5a);
         chk(16'(ds_dir), 16'h1);
         wait_done(n == 3 ? HS_STALL : HS_ACK, 8'h5a, n == 2);
         chk(16'(n_launch - l0), 16'h3);
         clr_halt();
      end
   endtask

   task automatic t_ss_err();
      int l0 = n_launch;
      link_corrupt = 1'b1;
      req(7'h07, 4'h3, 1'b0, 1'b0, 8'h00);
      wait_done(HS_STALL, 8'h00, 1'b0);
      chk(16'({halted, err_count}), 16'h7);
      chk(16'(n_launch - l0), 16'h0);
      link_corrupt = 1'b0;
      clr_halt();
      sys_hold = 1'b1;
      link_corrupt = 1'b1;
      req(7'h07, 4'h3, 1'b0, 1'b0, 8'h21);
      tick(60);
      chk(16'(err_count), 16'h0);
      link_corrupt = 1'b0;
      ds_serve(0, DS_ACK, 8'h22);
      wait_done(HS_ACK, 8'h22, 1'b1);
      sys_hold = 1'b0;
   endtask

   // The answer to the start-split is let through, then every complete-split is damaged.
   task automatic t_cs_err(input logic [ADDR_W-1:0] a, input logic c, input logic serve);
      int n = 0;
      req(a, 4'h4, 1'b0, c, 8'h11);
      while (lk_if.hs_valid !== 1'b1 && n < 50) begin
         tick(1);
         n++;
      end
      chk(16'(lk_if.hs_valid), 16'h1);
      link_corrupt = 1'b1;
      if (serve) ds_serve(0, DS_ACK, 8'h3c);
      wait_done(HS_STALL, 8'h00, 1'b0);
      chk(16'({halted, err_count}), 16'h7);
      link_corrupt = 1'b0;
      clr_halt();
   endtask

   task automatic t_full();
      int l0;
      t_cs_err(7'h08, 1'b1, 1'b1);
      t_cs_err(7'h09, 1'b0, 1'b0);
      req(7'h0a, 4'h4, 1'b0, 1'b0, 8'h00);
      wait_done(HS_NAK, 8'h00, 1'b0);
      chk(16'(err_count), 16'h0);
      ds_pulse(DS_ACK, 8'h77);
      l0 = n_launch;
      req(7'h08, 4'h4, 1'b1, 1'b1, 8'hee);
      wait_done(HS_ACK, 8'h3c, 1'b1);
      chk(16'(n_launch - l0), 16'h0);
      req(7'h09, 4'h4, 1'b0, 1'b0, 8'h00);
      wait_done(HS_ACK, 8'h77, 1'b1);
      req(7'h0a, 4'h4, 1'b0, 1'b0, 8'h00);
      ds_serve(0, DS_ACK, 8'h99);
      wait_done(HS_ACK, 8'h99, 1'b1);
   endtask

   initial begin
      tick(5);
      sys_rst = 1'b0;
      chk(16'({req_ready, halted, done}), 16'h4);
      t_results();
      t_local();
      t_ss_err();
      t_full();
      wrap_up();
   end

   // The whole run needs a few hundred cycles, so this only trips on a hang.
   initial begin
      tick(20000);
      n_errors++;
      wrap_up();
   end
endmodule // tb
`default_nettype wire
